// file: sldseq_top.v
// Startup lamp sequencer: lamp check, error code display, initialization, live display.
// Assumes self-test results and battery state are settled before the HIGH8 lamp phase ends
// and come from same-clock logic; bus activity and input switches are pins.
`timescale 1ns/1ns
`include "sldseq_defines.vh"
module sldseq_top #(
    parameter [35:0] ALL_ON_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_ALL_ON_MS),
    parameter [35:0] STEP_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_STEP_MS),
    parameter [35:0] CODE_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_CODE_MS),
    parameter [35:0] DARK_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_DARK_MS),
    parameter [35:0] RESTORE_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_RESTORE_MS),
    parameter [35:0] BUS_TO_IN_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_BUS_TO_IN_MS),
    parameter [35:0] IN_TO_OUT_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_IN_TO_OUT_MS),
    parameter [35:0] FLASH_HALF_CYC = `SLDSEQ_FLASH_HALF_CYC,
    parameter [35:0] BLINK_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_BLINK_MS),
    parameter [35:0] ACT_CYC = `SLDSEQ_MS_CYC(`SLDSEQ_ACT_MS)
) (
    // Clock, reset, enable
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    // Self-test results, same clock
    input wire [`SLDSEQ_NERR-1:0] err_detect_i,
    input wire [`SLDSEQ_NERR-1:0] err_disabling_i,
    input wire battery_low_i,
    // Daily and service events, same-clock pulses
    input wire midnight_retest_i,
    input wire service_test_i,
    // Pins
    input wire bus_activity_i,
    input wire [15:0] input_state_i,
    // Program results, same clock
    input wire [15:0] output_state_i,
    // Lamps
    output reg [15:0] input_lamp_o,
    output reg [3:0] status_lamp_o,
    output reg [15:0] output_lamp_o,
    // Archive and restore requests, one-cycle pulses
    output reg archive_req_o,
    output reg restore_req_o,
    // Logged non-disabling errors and progress
    output reg [`SLDSEQ_NERR-1:0] err_log_o,
    output reg startup_done_o
);
    localparam [3:0] ST_ALL = 4'h0;
    localparam [3:0] ST_WALK = 4'h1;
    localparam [3:0] ST_LOW8 = 4'h2;
    localparam [3:0] ST_HIGH8 = 4'h3;
    localparam [3:0] ST_ERR = 4'h4;
    localparam [3:0] ST_DARK = 4'h5;
    localparam [3:0] ST_BUS = 4'h6;
    localparam [3:0] ST_INPUTS = 4'h7;
    localparam [3:0] ST_RUN = 4'h8;

    reg [3:0] state;
    reg [1:0] walk;
    reg [3:0] err_idx;
    reg [`SLDSEQ_NERR-1:0] err_snap;
    reg [`SLDSEQ_NERR-1:0] dis_snap;
    reg restoring;
    reg batt_warn;
    reg enter;
    reg [35:0] enter_cnt;
    reg [1:0] bus_sync;
    reg [15:0] in_meta;
    reg [15:0] in_sync;
    reg [31:0] act_cnt;
    reg [3:0] next_idx;
    reg next_found;
    wire tmr_done;
    wire flash_wave;
    wire blink_wave;
    integer k;

    sldseq_timer u_timer (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(clk_en_i),
        .load_i(enter),
        .count_i(enter_cnt),
        .done_o(tmr_done)
    );

    sldseq_toggle #(
        .HALF(FLASH_HALF_CYC)
    ) u_flash (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(clk_en_i),
        .restart_i(enter),
        .wave_o(flash_wave)
    );

    sldseq_toggle #(
        .HALF(BLINK_CYC)
    ) u_blink (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(clk_en_i),
        .restart_i(1'b0),
        .wave_o(blink_wave)
    );

    // next pending error after the current index
    always @* begin
        next_idx = 4'h0;
        next_found = 1'b0;
        for (k = `SLDSEQ_NERR - 1; k >= 0; k = k - 1) begin
            if (err_snap[k] && (err_idx == 4'hF || k > err_idx)) begin
                next_idx = k[3:0];
                next_found = 1'b1;
            end
        end
    end

    // Pins pass two flops before anything looks at them.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            bus_sync <= 2'h0;
            in_meta <= 16'h0000;
            in_sync <= 16'h0000;
        end else if (clk_en_i) begin
            bus_sync <= {bus_sync[0], bus_activity_i};
            in_meta <= input_state_i;
            in_sync <= in_meta;
        end
    end

    // Sequencer. The timer is reloaded one cycle after each state entry except ST_RUN, via enter.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state <= ST_ALL;
            walk <= 2'h0;
            err_idx <= 4'hF;
            err_snap <= {`SLDSEQ_NERR{1'b0}};
            dis_snap <= {`SLDSEQ_NERR{1'b0}};
            err_log_o <= {`SLDSEQ_NERR{1'b0}};
            restoring <= 1'b0;
            batt_warn <= 1'b0;
            enter <= 1'b1;
            enter_cnt <= ALL_ON_CYC;
            archive_req_o <= 1'b0;
            restore_req_o <= 1'b0;
            startup_done_o <= 1'b0;
        end else if (clk_en_i) begin
            enter <= 1'b0;
            archive_req_o <= 1'b0;
            restore_req_o <= 1'b0;
            if (midnight_retest_i) begin
                archive_req_o <= 1'b1;
            end
            if (midnight_retest_i || service_test_i) begin
                batt_warn <= battery_low_i;
            end
            case (state)
                ST_ALL: begin
                    if (tmr_done) begin
                        state <= ST_WALK;
                        walk <= 2'h0;
                        enter <= 1'b1;
                        enter_cnt <= STEP_CYC;
                    end
                end
                ST_WALK: begin
                    // one status lamp at a time
                    if (tmr_done) begin
                        enter <= 1'b1;
                        enter_cnt <= STEP_CYC;
                        if (walk == 2'h3) begin
                            state <= ST_LOW8;
                        end else begin
                            walk <= walk + 2'h1;
                        end
                    end
                end
                ST_LOW8: begin
                    if (tmr_done) begin
                        state <= ST_HIGH8;
                        enter <= 1'b1;
                        enter_cnt <= STEP_CYC;
                    end
                end
                ST_HIGH8: begin
                    if (tmr_done) begin
                        err_snap <= err_detect_i;
                        dis_snap <= err_disabling_i;
                        err_log_o <= err_detect_i & ~err_disabling_i;
                        batt_warn <= battery_low_i;
                        restoring <= battery_low_i;
                        err_idx <= 4'hF;
                        state <= ST_ERR;
                        enter <= 1'b1;
                        enter_cnt <= 36'h0_0000_0001;
                    end
                end
                ST_ERR: begin
                    if (tmr_done) begin
                        enter <= 1'b1;
                        if (next_found && err_idx != 4'hE) begin
                            err_idx <= next_idx;
                            enter_cnt <= CODE_CYC;
                        end else if (err_idx != 4'hF && err_idx != 4'hE) begin
                            // One blank code slot separates the last code from the dark phase.
                            err_idx <= 4'hE;
                            enter_cnt <= CODE_CYC;
                        end else begin
                            state <= ST_DARK;
                            err_idx <= 4'hF;
                            enter_cnt <= restoring ? RESTORE_CYC : DARK_CYC;
                            restore_req_o <= restoring;
                        end
                    end
                end
                ST_DARK: begin
                    if (tmr_done) begin
                        state <= ST_BUS;
                        enter <= 1'b1;
                        enter_cnt <= BUS_TO_IN_CYC;
                    end
                end
                ST_BUS: begin
                    if (tmr_done) begin
                        state <= ST_INPUTS;
                        enter <= 1'b1;
                        enter_cnt <= IN_TO_OUT_CYC;
                    end
                end
                ST_INPUTS: begin
                    if (tmr_done) begin
                        state <= ST_RUN;
                        startup_done_o <= 1'b1;
                    end
                end
                ST_RUN: begin
                    startup_done_o <= 1'b1;
                end
                default: begin
                    state <= ST_ALL;
                    enter <= 1'b1;
                    enter_cnt <= ALL_ON_CYC;
                end
            endcase
        end
    end

    // Bus activity is stretched so short traffic bursts are still seen.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            act_cnt <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (bus_sync[1]) begin
                act_cnt <= ACT_CYC[31:0];
            end else if (act_cnt != 32'h0000_0000) begin
                act_cnt <= act_cnt - 32'h0000_0001;
            end
        end
    end

    // Lamp drivers, all registered.
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            input_lamp_o <= 16'h0000;
            status_lamp_o <= 4'h0;
            output_lamp_o <= 16'h0000;
        end else if (clk_en_i) begin
            input_lamp_o <= 16'h0000;
            status_lamp_o <= 4'h0;
            output_lamp_o <= 16'h0000;
            case (state)
                ST_ALL: begin
                    input_lamp_o <= 16'hFFFF;
                    status_lamp_o <= 4'hF;
                end
                ST_WALK: begin
                    status_lamp_o <= 4'h1 << walk;
                end
                ST_LOW8: begin
                    input_lamp_o <= 16'h00FF;
                end
                ST_HIGH8: begin
                    input_lamp_o <= 16'hFF00;
                end
                ST_ERR: begin
                    if (err_idx < `SLDSEQ_NERR) begin
                        status_lamp_o[`SLDSEQ_ST_ERR] <= dis_snap[err_idx] ? flash_wave : 1'b1;
                        case (err_idx)
                            `SLDSEQ_E_BATT: input_lamp_o[0] <= 1'b1;
                            `SLDSEQ_E_CRC_START: input_lamp_o[3] <= 1'b1;
                            `SLDSEQ_E_CRC_MAIN: input_lamp_o[4] <= 1'b1;
                            `SLDSEQ_E_CRC_CFG: input_lamp_o[5] <= 1'b1;
                            `SLDSEQ_E_RAM_LO: input_lamp_o[6] <= 1'b1;
                            `SLDSEQ_E_RAM_HI: input_lamp_o[7] <= 1'b1;
                            `SLDSEQ_E_BUS485: status_lamp_o[`SLDSEQ_ST_BUS] <= 1'b1;
                            `SLDSEQ_E_RS232: status_lamp_o[`SLDSEQ_ST_SER] <= 1'b1;
                            `SLDSEQ_E_FIELD: input_lamp_o[1] <= 1'b1;
                            `SLDSEQ_E_EXP: input_lamp_o[2] <= 1'b1;
                            `SLDSEQ_E_IP: status_lamp_o[`SLDSEQ_ST_IP] <= 1'b1;
                            default: input_lamp_o <= 16'h0000;
                        endcase
                    end
                end
                ST_DARK: begin
                    input_lamp_o <= 16'h0000;
                end
                ST_BUS: begin
                    status_lamp_o[`SLDSEQ_ST_BUS] <= (act_cnt != 32'h0000_0000);
                end
                ST_INPUTS: begin
                    status_lamp_o[`SLDSEQ_ST_BUS] <= (act_cnt != 32'h0000_0000);
                    input_lamp_o <= in_sync;
                end
                ST_RUN: begin
                    status_lamp_o[`SLDSEQ_ST_BUS] <= (act_cnt != 32'h0000_0000);
                    input_lamp_o <= in_sync;
                    output_lamp_o <= output_state_i;
                    status_lamp_o[`SLDSEQ_ST_ERR] <= batt_warn & blink_wave;
                end
                default: begin
                    input_lamp_o <= 16'h0000;
                end
            endcase
        end
    end
endmodule

// file: sldseq_defines.vh
// Timing constants and lamp map for the startup lamp sequencer.
// Assumes a 100 MHz core clock; all times are converted to cycle counts here.
`ifndef SLDSEQ_DEFINES_VH
`define SLDSEQ_DEFINES_VH

`define SLDSEQ_CLK_HZ 100000000
// Durations in milliseconds, each picked inside its allowed range.
`define SLDSEQ_ALL_ON_MS 2000
`define SLDSEQ_STEP_MS 500
`define SLDSEQ_CODE_MS 3000
`define SLDSEQ_DARK_MS 10000
`define SLDSEQ_RESTORE_MS 90000
`define SLDSEQ_BUS_TO_IN_MS 1500
`define SLDSEQ_IN_TO_OUT_MS 17000
// Error-lamp flash of a disabling error, in millihertz.
`define SLDSEQ_FLASH_MHZ 5900
// Battery warning blink half period, one second on and one off.
`define SLDSEQ_BLINK_MS 1000
// Activity lamp stretch so a single bus pulse is visible.
`define SLDSEQ_ACT_MS 50

// Cycle counts are 36 bits wide: the 90 s restore interval overflows 32 bits.
`define SLDSEQ_MS_CYC(ms) ((ms) * (`SLDSEQ_CLK_HZ / 1000) * 36'h0_0000_0001)
// Half period of the flash, rounded down.
`define SLDSEQ_FLASH_HALF_CYC ((`SLDSEQ_CLK_HZ / 2 * 36'h0_0000_03E8) / `SLDSEQ_FLASH_MHZ)

// Number of startup error kinds, and their bit positions.
`define SLDSEQ_NERR 11
`define SLDSEQ_E_BATT 0
`define SLDSEQ_E_CRC_START 1
`define SLDSEQ_E_CRC_MAIN 2
`define SLDSEQ_E_CRC_CFG 3
`define SLDSEQ_E_RAM_LO 4
`define SLDSEQ_E_RAM_HI 5
`define SLDSEQ_E_BUS485 6
`define SLDSEQ_E_RS232 7
`define SLDSEQ_E_FIELD 8
`define SLDSEQ_E_EXP 9
`define SLDSEQ_E_IP 10

// Status lamp bits: 0 bus, 1 serial, 2 ip/ethernet, 3 error.
`define SLDSEQ_ST_BUS 0
`define SLDSEQ_ST_SER 1
`define SLDSEQ_ST_IP 2
`define SLDSEQ_ST_ERR 3

`endif

// file: sldseq_timer.v
// Loadable down counter that pulses done when a loaded interval expires.
// Assumes load and count come from logic on the same clock.
`timescale 1ns/1ns
module sldseq_timer (
    // Clock and control
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    // Interval
    input wire load_i,
    input wire [35:0] count_i,
    output reg done_o
);
    reg [35:0] remain;

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            remain <= 36'h0_0000_0000;
            done_o <= 1'b0;
        end else if (ce_i) begin
            done_o <= 1'b0;
            if (load_i) begin
                remain <= count_i;
            end else if (remain != 36'h0_0000_0000) begin
                remain <= remain - 36'h0_0000_0001;
                if (remain == 36'h0_0000_0001) begin
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule

// file: sldseq_toggle.v
// Free running square wave of a given half period, restartable.
// Assumes restart and enable come from logic on the same clock.
`timescale 1ns/1ns
module sldseq_toggle #(
    parameter [35:0] HALF = 36'h0_0000_0002
) (
    // Clock and control
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire ce_i,
    input wire restart_i,
    // Wave
    output reg wave_o
);
    reg [35:0] cnt;

    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt <= 36'h0_0000_0000;
            wave_o <= 1'b0;
        end else if (ce_i) begin
            if (restart_i) begin
                cnt <= 36'h0_0000_0000;
                wave_o <= 1'b1;
            end else if (cnt >= HALF - 36'h0_0000_0001) begin
                cnt <= 36'h0_0000_0000;
                wave_o <= ~wave_o;
            end else begin
                cnt <= cnt + 36'h0_0000_0001;
            end
        end
    end
endmodule

// file: sldseq_top_assertions.sv
// Checker for the startup lamp sequencer, watching the top-level ports only.
// Assumes the short-test intervals of the bench: five-cycle walk steps.
`timescale 1ns/1ns
module sldseq_chk (
    // Clock and control
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    input wire midnight_retest_i,
    input wire [15:0] output_state_i,
    // Design outputs
    input wire [15:0] input_lamp_o,
    input wire [3:0] status_lamp_o,
    input wire [15:0] output_lamp_o,
    input wire archive_req_o,
    input wire restore_req_o,
    input wire startup_done_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    walk_enter_a: assert property (!$past(sys_rst_i) && $past(status_lamp_o) == 4'hF
        && status_lamp_o != 4'hF |-> status_lamp_o == 4'h1 && input_lamp_o == 16'h0000)
        else $error("all-on phase did not hand over to the bus lamp alone");
    walk_step_a: assert property (status_lamp_o == 4'h1 && $past(status_lamp_o) == 4'hF
        |-> status_lamp_o == 4'h1 [*3] ##[1:5] status_lamp_o == 4'h2)
        else $error("bus lamp step was not followed by the serial lamp");
    out_dark_a: assert property (!startup_done_o |-> output_lamp_o == 16'h0000)
        else $error("output lamps lit before startup completed");
    done_hold_a: assert property (startup_done_o |=> startup_done_o)
        else $error("startup done dropped without reset");
    live_out_a: assert property (startup_done_o && $past(startup_done_o) && $past(clk_en_i)
        |-> output_lamp_o == $past(output_state_i))
        else $error("output lamps do not follow program results");
    archive_pulse_a: assert property (startup_done_o && midnight_retest_i && clk_en_i
        |=> archive_req_o)
        else $error("midnight event gave no archive request");
    archive_cause_a: assert property (archive_req_o |-> $past(midnight_retest_i))
        else $error("archive request without a midnight event");
    restore_dark_a: assert property (restore_req_o
        |-> input_lamp_o == 16'h0000 && status_lamp_o == 4'h0 && !startup_done_o)
        else $error("restore request outside the dark interval");
    freeze_a: assert property (!clk_en_i
        |=> $stable({input_lamp_o, status_lamp_o, output_lamp_o, startup_done_o}))
        else $error("outputs moved while the clock enable was low");
endmodule

bind sldseq_top sldseq_chk u_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .midnight_retest_i(midnight_retest_i), .output_state_i(output_state_i),
    .input_lamp_o(input_lamp_o), .status_lamp_o(status_lamp_o),
    .output_lamp_o(output_lamp_o), .archive_req_o(archive_req_o),
    .restore_req_o(restore_req_o), .startup_done_o(startup_done_o)
);

// file: sldseq_panel.sv
// Far-side model: bus traffic source and the bank of input switches.
// Assumes the bench supplies the clock it paces traffic from and the switch setting.
`timescale 1ns/1ns
module sldseq_panel (
    // Pacing and setting
    input wire core_clk_i,
    input wire traffic_en_i,
    input wire [15:0] switch_i,
    // Pins toward the sequencer
    output reg bus_activity_o,
    output reg [15:0] input_state_o
);
    integer cnt = 0;
    initial bus_activity_o = 1'b0;
    initial input_state_o = 16'h0000;
    // sparse bus traffic
    // Pulses are spaced wider than the lamp stretch so the lamp really blinks.
    always @(negedge core_clk_i) begin
        cnt = (cnt + 1) % 7;
        bus_activity_o <= traffic_en_i && cnt == 0;
    end
    always @(negedge core_clk_i) begin
        input_state_o <= switch_i;
    end
endmodule

// file: startup_led_diagnostic_sequencer_test.sv
// Self-checking bench for the startup lamp sequencer with short intervals.
// Assumes the partner model drives the pins; all other inputs change at falling edges.
`timescale 1ns/1ns
`include "sldseq_defines.vh"
module startup_led_diagnostic_sequencer_test;
    reg core_clk_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg clk_en_i = 1'b1;
    reg [`SLDSEQ_NERR-1:0] err_detect_i = 11'h000;
    reg [`SLDSEQ_NERR-1:0] err_disabling_i = 11'h000;
    reg battery_low_i = 1'b0;
    reg midnight_retest_i = 1'b0;
    reg service_test_i = 1'b0;
    reg traffic_en = 1'b0;
    reg [15:0] switches = 16'h0000;
    reg [15:0] output_state_i = 16'h0000;
    wire bus_activity_i;
    wire [15:0] input_state_i;
    wire [15:0] input_lamp_o;
    wire [3:0] status_lamp_o;
    wire [15:0] output_lamp_o;
    wire archive_req_o;
    wire restore_req_o;
    wire [`SLDSEQ_NERR-1:0] err_log_o;
    wire startup_done_o;
    integer n_fail = 0;
    integer checked = 0;
    integer cycles = 0;
    integer n_arch = 0;
    integer n_rest = 0;
    integer rises = 0;
    integer seed_v;
    integer a0;
    // Short intervals keep the whole run to under 1400 cycles.
    localparam integer T_ALL = 20;
    localparam integer T_STEP = 5;
    localparam integer T_CODE = 30;
    localparam integer T_DARK = 10;
    localparam integer T_REST = 40;
    localparam integer T_BUS = 8;
    localparam integer T_IN = 12;
    localparam integer T_FLASH = 2;
    localparam integer T_BLINK = 4;
    localparam integer T_ACT = 3;

    sldseq_top #(.ALL_ON_CYC(T_ALL), .STEP_CYC(T_STEP), .CODE_CYC(T_CODE),
        .DARK_CYC(T_DARK), .RESTORE_CYC(T_REST), .BUS_TO_IN_CYC(T_BUS),
        .IN_TO_OUT_CYC(T_IN), .FLASH_HALF_CYC(T_FLASH), .BLINK_CYC(T_BLINK),
        .ACT_CYC(T_ACT)) u_dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .err_detect_i(err_detect_i), .err_disabling_i(err_disabling_i),
        .battery_low_i(battery_low_i), .midnight_retest_i(midnight_retest_i),
        .service_test_i(service_test_i), .bus_activity_i(bus_activity_i),
        .input_state_i(input_state_i), .output_state_i(output_state_i),
        .input_lamp_o(input_lamp_o), .status_lamp_o(status_lamp_o),
        .output_lamp_o(output_lamp_o), .archive_req_o(archive_req_o),
        .restore_req_o(restore_req_o), .err_log_o(err_log_o),
        .startup_done_o(startup_done_o));

    sldseq_panel u_panel (.core_clk_i(core_clk_i), .traffic_en_i(traffic_en),
        .switch_i(switches), .bus_activity_o(bus_activity_i),
        .input_state_o(input_state_i));

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", checked, n_fail);
            if (n_fail == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // The whole run needs about 1000 to 1400 cycles; the ceiling leaves wide margin.
    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (archive_req_o === 1'b1) n_arch = n_arch + 1;
        if (restore_req_o === 1'b1) n_rest = n_rest + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
    end

    task check(input [35:0] got, input [35:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // Lamp pair of each error kind, as {input lamps, status lamps}.
    function [19:0] code_lamp(input integer b);
        begin
            case (b)
                0: code_lamp = {16'h0001, 4'h8};
                6: code_lamp = {16'h0000, 4'h9};
                7: code_lamp = {16'h0000, 4'hA};
                8: code_lamp = {16'h0002, 4'h8};
                9: code_lamp = {16'h0004, 4'h8};
                10: code_lamp = {16'h0000, 4'hC};
                default: code_lamp = {16'h0001 << (b + 2), 4'h8};
            endcase
        end
    endfunction

    // Waits for a lamp pattern, then holds it for most of its interval; status
    // bits cleared in m are free, and their rising edges are counted.
    task phase(input [15:0] ein, input [3:0] est, input integer len, input [3:0] m);
        integer k;
        integer w;
        reg [3:0] pv;
        begin
            w = 0;
            while ((input_lamp_o !== ein || (status_lamp_o & m) !== (est & m)) && w < 8) begin
                @(negedge core_clk_i);
                w = w + 1;
            end
            rises = 0;
            pv = status_lamp_o & ~m;
            for (k = 0; k < len - 3; k = k + 1) begin
                check({input_lamp_o, status_lamp_o & m, output_lamp_o}, {ein, est & m, 16'h0});
                if (((status_lamp_o & ~m) & ~pv) != 4'h0) rises = rises + 1;
                pv = status_lamp_o & ~m;
                @(negedge core_clk_i);
            end
            if (est[3] && !m[3]) check(rises >= 5, 1'b1);
        end
    endtask

    task observe(input w);
        integer k;
        integer r;
        reg p;
        begin
            repeat (3) @(negedge core_clk_i);
            r = 0;
            p = status_lamp_o[3];
            for (k = 0; k < 40; k = k + 1) begin
                output_state_i = $urandom;
                @(negedge core_clk_i);
                if (status_lamp_o[3] && !p) r = r + 1;
                p = status_lamp_o[3];
                check(input_lamp_o, switches);
                check(output_lamp_o, output_state_i);
            end
            check(w ? r >= 3 : r == 0, 1'b1);
        end
    endtask

    task run_seq(input [10:0] det, input [10:0] dis, input batt);
        integer b;
        integer r;
        begin
            @(negedge core_clk_i);
            sys_rst_i = 1'b1;
            err_detect_i = det;
            err_disabling_i = dis;
            battery_low_i = batt;
            switches = $urandom;
            traffic_en = 1'b1;
            repeat (10) @(negedge core_clk_i);
            n_rest = 0;
            sys_rst_i = 1'b0;
            phase(16'hFFFF, 4'hF, T_ALL, 4'hF);
            for (b = 0; b < 4; b = b + 1)
                phase(16'h0000, 4'h1 << b, T_STEP, 4'hF);
            phase(16'h00FF, 4'h0, T_STEP, 4'hF);
            phase(16'hFF00, 4'h0, T_STEP, 4'hF);
            for (b = 0; b < 11; b = b + 1)
                if (det[b])
                    phase(code_lamp(b) >> 4, code_lamp(b), T_CODE, dis[b] ? 4'h7 : 4'hF);
            check(err_log_o, det & ~dis);
            // Dark span: a blank code slot after any code, then the dark state.
            phase(16'h0000, 4'h0, (det != 0 ? T_CODE + 7 : 8) + (batt ? T_REST : T_DARK), 4'hF);
            check(n_rest, batt);
            phase(16'h0000, 4'h0, T_BUS, 4'hE);
            r = rises;
            phase(switches, 4'h0, T_IN, 4'hE);
            check(r + rises >= 1, 1'b1);
            b = 0;
            while (startup_done_o !== 1'b1 && b < 8) begin
                @(negedge core_clk_i);
                b = b + 1;
            end
            check(startup_done_o, 1'b1);
            observe(batt);
        end
    endtask

    initial begin
        seed_v = $urandom(92);
        run_seq(11'h000, 11'h000, 1'b0);
        run_seq(11'h7FF, 11'h03E, 1'b1);
        run_seq($urandom, $urandom, 1'b0);
        clk_en_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        clk_en_i = 1'b1;
        battery_low_i = 1'b1;
        service_test_i = 1'b1;
        @(negedge core_clk_i);
        service_test_i = 1'b0;
        observe(1'b1);
        a0 = n_arch;
        battery_low_i = 1'b0;
        // Two midnight events back to back must each ask for an archive.
        midnight_retest_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        midnight_retest_i = 1'b0;
        observe(1'b0);
        check(n_arch - a0, 2);
        wrap_up;
    end
endmodule
